// ---- include/wspc_pkg.sv ----
package wspc_pkg;
    // interrupt option register: global enable bit position and reset value
    localparam logic [7:0] WSPC_IOPT_ADDR = 8'hc8;
    localparam logic [7:0] WSPC_IOPT_RESET = 8'h00;
    localparam int WSPC_GIE_BIT = 4;
    // oscillator settle time after stop exit
    localparam int WSPC_CLK_MHZ = 200;
    localparam int WSPC_SETTLE_US = 1000;
    localparam int WSPC_SETTLE_CYC = WSPC_SETTLE_US * WSPC_CLK_MHZ;

    typedef enum logic [1:0]
    {
        WSPC_MODE_MAIN,
        WSPC_MODE_IRQ,
        WSPC_MODE_NMI
    } wspc_core_mode_t;

    typedef enum logic [1:0]
    {
        WSPC_RESUME_NONE,
        WSPC_RESUME_NEXT,
        WSPC_RESUME_SERVICE
    } wspc_resume_t;

    // request from core: low-power instruction executed
    typedef struct packed
    {
        logic wait_req;
        logic stop_req;
        wspc_core_mode_t mode;
    } wspc_entry_t;

    // wake report to core
    typedef struct packed
    {
        logic wake;
        wspc_resume_t action;
        logic nmi_first;
        logic stay_mode;
    } wspc_wake_t;
endpackage

// ---- logic/wspc_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - wait halts fetch, keeps state, peripherals run
// - oscillator keeps peripheral clock during wait
// - wait exit by interrupt has no delay
// - any reset ends wait normally
// - stop halts oscillator, waits interrupt or reset
// - pin reset ends stop via reset
// - stop exit inserts oscillator settle delay
// - active watchdog turns stop into wait
// - main mode wake services interrupt then next
// - nmi mode wake continues, stays nmi
// - irq mode normal wake continues routine
// - irq mode nmi wake runs nmi first
// - wake leaves oscillator selection unchanged
// - global enable low blocks all wake-up
// - pending enabled request refuses entry
// - global enable is write-only option bit 4
module wspc_ctrl #(
    parameter int SETTLE_CYC = wspc_pkg::WSPC_SETTLE_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire wspc_pkg::wspc_entry_t entry_i,
    input wire logic opt_wr_i,
    input wire logic [7:0] opt_addr_i,
    input wire logic [7:0] opt_data_i,
    input wire logic irq_pend_i,
    input wire logic nmi_pend_i,
    input wire logic wdg_hw_i,
    input wire logic wdg_sw_i,
    input wire logic [1:0] osc_sel_i,
    output logic core_halt_o,
    output logic osc_run_o,
    output logic periph_clk_en_o,
    output logic [1:0] osc_sel_o,
    output logic global_interrupt_enable_o,
    output logic entry_refused_o,
    output wspc_pkg::wspc_wake_t wake_o
);
    import wspc_pkg::*;

    initial
    begin
        if (SETTLE_CYC < 1)
        begin
            $error("SETTLE_CYC must be at least one");
        end
    end

    typedef enum logic [1:0]
    {
        WSPC_RUN,
        WSPC_WAIT,
        WSPC_STOP,
        WSPC_SETTLE
    } wspc_state_t;

    localparam int CW = $clog2(SETTLE_CYC + 1);

    wspc_state_t state_q;
    wspc_core_mode_t mode_q;
    logic [CW-1:0] cnt_q;
    logic gie_q;
    logic nmi_wake_q;
    logic [1:0] osc_sel_q;

    logic wake_ev;
    logic enabled_pend;
    logic stop_as_wait;
    logic low_req;
    logic accept;
    logic enter_stop;
    logic stop_hold;
    logic resume_now;

    // nmi stays serviceable but only wakes with global enable set
    assign wake_ev = gie_q && (irq_pend_i || nmi_pend_i);
    assign enabled_pend = gie_q && irq_pend_i || nmi_pend_i;
    assign stop_as_wait = wdg_hw_i || wdg_sw_i;
    assign low_req = entry_i.wait_req || entry_i.stop_req;
    assign accept = state_q == WSPC_RUN && low_req && !enabled_pend;
    assign enter_stop = accept && entry_i.stop_req && !stop_as_wait;
    // stop entry drops the clock at once, not a cycle late
    assign stop_hold = enter_stop || (state_q == WSPC_STOP && !wake_ev);
    // both wake paths end here; the core restarts with the pulse
    assign resume_now = (state_q == WSPC_WAIT && wake_ev) ||
        (state_q == WSPC_SETTLE && cnt_q <= CW'(1));

    // write-only; single-bit ops are the core's concern, not ours
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gie_q <= WSPC_IOPT_RESET[WSPC_GIE_BIT];
        end
        else if (opt_wr_i && opt_addr_i == WSPC_IOPT_ADDR)
        begin
            gie_q <= opt_data_i[WSPC_GIE_BIT];
        end
    end

    // reset is async: it ends wait or stop at once
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= WSPC_RUN;
        end
        else
        begin
            case (state_q)
                WSPC_RUN:
                begin
                    if (accept)
                    begin
                        if (enter_stop)
                        begin
                            state_q <= WSPC_STOP;
                        end
                        else
                        begin
                            state_q <= WSPC_WAIT;
                        end
                    end
                end
                WSPC_WAIT:
                begin
                    if (wake_ev)
                    begin
                        state_q <= WSPC_RUN;
                    end
                end
                WSPC_STOP:
                begin
                    if (wake_ev)
                    begin
                        state_q <= WSPC_SETTLE;
                    end
                end
                WSPC_SETTLE:
                begin
                    if (cnt_q <= CW'(1))
                    begin
                        state_q <= WSPC_RUN;
                    end
                end
                default:
                begin
                    state_q <= WSPC_RUN;
                end
            endcase
        end
    end

    // mode taken at entry only; later mode changes cannot alter resume
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= WSPC_MODE_MAIN;
        end
        else if (accept)
        begin
            mode_q <= entry_i.mode;
        end
    end

    // nmi seen at stop wake is kept until the settle ends
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            nmi_wake_q <= 1'b0;
        end
        else if ((state_q == WSPC_WAIT || state_q == WSPC_STOP) &&
            wake_ev)
        begin
            nmi_wake_q <= nmi_pend_i;
        end
    end

    // settle counter runs on the local clock while the oscillator restarts
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= '0;
        end
        else if (state_q == WSPC_STOP && wake_ev)
        begin
            cnt_q <= CW'(SETTLE_CYC);
        end
        else if (state_q == WSPC_SETTLE)
        begin
            if (cnt_q <= CW'(1))
            begin
                cnt_q <= '0;
            end
            else
            begin
                cnt_q <= cnt_q - CW'(1);
            end
        end
    end

    // halt and clock outputs registered from next state view
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            core_halt_o <= 1'b0;
            osc_run_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
        end
        else
        begin
            // halt falls together with the wake pulse
            core_halt_o <= (state_q != WSPC_RUN && !resume_now) ||
                accept;
            osc_run_o <= !stop_hold;
            periph_clk_en_o <= !stop_hold;
        end
    end

    // oscillator selection only follows the core, never a wake
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_sel_q <= 2'h0;
        end
        else
        begin
            osc_sel_q <= osc_sel_i;
        end
    end
    assign osc_sel_o = osc_sel_q;

    // visible copy lags the write by one cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            global_interrupt_enable_o <= 1'b0;
        end
        else
        begin
            global_interrupt_enable_o <= gie_q;
        end
    end

    // refusal pulse, so the core knows to service instead
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            entry_refused_o <= 1'b0;
        end
        else
        begin
            entry_refused_o <= state_q == WSPC_RUN && low_req &&
                enabled_pend;
        end
    end

    // resume decision, one-cycle pulse at return to run
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wake_o <= '0;
        end
        else
        begin
            wake_o <= '0;
            if (resume_now)
            begin
                wake_o.wake <= 1'b1;
                case (mode_q)
                    WSPC_MODE_MAIN:
                    begin
                        wake_o.action <= WSPC_RESUME_SERVICE;
                    end
                    WSPC_MODE_NMI:
                    begin
                        wake_o.action <= WSPC_RESUME_NEXT;
                        wake_o.stay_mode <= 1'b1;
                    end
                    default:
                    begin
                        wake_o.action <= WSPC_RESUME_NEXT;
                        wake_o.stay_mode <= 1'b1;
                        wake_o.nmi_first <= state_q == WSPC_WAIT ?
                            nmi_pend_i : nmi_wake_q;
                    end
                endcase
            end
        end
    end
endmodule

// ---- tb/wspc_ctrl_properties.sv ----
`timescale 1ns/1ps
module wspc_ctrl_properties #(parameter int SETTLE_CYC = 4)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire wspc_pkg::wspc_entry_t entry_i,
    input wire logic irq_pend_i,
    input wire logic nmi_pend_i,
    input wire logic wdg_hw_i,
    input wire logic wdg_sw_i,
    input wire logic core_halt_o,
    input wire logic osc_run_o,
    input wire logic global_interrupt_enable_o,
    input wire logic entry_refused_o,
    input wire wspc_pkg::wspc_wake_t wake_o
);
    import wspc_pkg::*;
    localparam int HI = SETTLE_CYC + 2;
    logic stop_q;
    wire logic gie = global_interrupt_enable_o;
    wire logic refuse = nmi_pend_i | (gie & irq_pend_i);
    wire logic any_req = entry_i.wait_req | entry_i.stop_req;
    wire logic acc = any_req & ~core_halt_o & ~refuse;
    wire logic wdg = wdg_hw_i | wdg_sw_i;
    wire logic wake = wake_o.wake;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // true stop only; a watchdog stop behaves as wait
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            stop_q <= 1'h0;
        else if (acc | wake)
            stop_q <= acc & entry_i.stop_req & ~wdg;
    property p_wait; acc & entry_i.wait_req |=> core_halt_o & osc_run_o;
    endproperty
    a_wait: assert property (p_wait) else $error("wait entry bad");
    property p_stop; acc & entry_i.stop_req & ~wdg |=> core_halt_o & ~osc_run_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop entry bad");
    property p_wdg; acc & entry_i.stop_req & wdg |=> core_halt_o & osc_run_o;
    endproperty
    a_wdg: assert property (p_wdg) else $error("stop not turned to wait");
    property p_fast;
        ~stop_q & core_halt_o & gie & (irq_pend_i | nmi_pend_i) |=> wake;
    endproperty
    a_fast: assert property (p_fast) else $error("wait exit late");
    property p_settle; stop_q & $rose(osc_run_o) |-> ~wake ##1 ~wake ##[1:HI] wake;
    endproperty
    a_settle: assert property (p_settle) else $error("settle bad");
    property p_gie; core_halt_o & ~gie |=> ~wake;
    endproperty
    a_gie: assert property (p_gie) else $error("wake with enable low");
    property p_refuse; any_req & ~core_halt_o & refuse |=> entry_refused_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("entry not refused");
    property p_hold;
        stop_q & ~osc_run_o & ~(gie & (irq_pend_i | nmi_pend_i)) |=> ~osc_run_o;
    endproperty
    a_hold: assert property (p_hold) else $error("stop left early");
endmodule
bind wspc_ctrl wspc_ctrl_properties #(.SETTLE_CYC(SETTLE_CYC)) props (.*);

// ---- tb/wspc_core_model.sv ----
`timescale 1ns/1ps
// request latches, dropped once the core takes the wake and services them
module wspc_core_model
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] set_i,
    input wire wspc_pkg::wspc_wake_t wake_i,
    output logic irq_pend_o,
    output logic nmi_pend_o
);
    import wspc_pkg::*;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            {nmi_pend_o, irq_pend_o} <= 2'h0;
        else if (wake_i.wake)
            {nmi_pend_o, irq_pend_o} <= 2'h0;
        else
            {nmi_pend_o, irq_pend_o} <= {nmi_pend_o, irq_pend_o} | set_i;
endmodule

// ---- tb/test_wspc_ctrl.sv ----
`timescale 1ns/1ps
module test_wspc_ctrl;
    import wspc_pkg::*;
    localparam int S = 4;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic opt_wr_i = 1'h0;
    logic wdg_hw_i = 1'h0;
    logic wdg_sw_i = 1'h0;
    logic [7:0] opt_addr_i = 8'h00;
    logic [7:0] opt_data_i = 8'h00;
    logic [1:0] set = 2'h0;
    logic [1:0] osc_sel_i = 2'h0;
    wspc_entry_t entry_i = '0;
    logic core_halt_o, osc_run_o, periph_clk_en_o, global_interrupt_enable_o;
    logic entry_refused_o, irq_pend_i, nmi_pend_i, se, nw;
    logic [1:0] osc_sel_o;
    wspc_wake_t wake_o;
    int failures = 0;
    int checked = 0;
    int seed = 32'hfa082c85;
    int n;
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    wspc_ctrl #(.SETTLE_CYC(S)) dut (.*);
    wspc_core_model model (.clk_i, .rst_n_i, .set_i(set), .wake_i(wake_o),
        .irq_pend_o(irq_pend_i), .nmi_pend_o(nmi_pend_i));
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_n_i <= 1'h0;
        tick(16);
        rst_n_i <= 1'h1;
        tick();
        check({core_halt_o, osc_run_o, periph_clk_en_o,
            global_interrupt_enable_o, wake_o.wake}, 8'h0c);
    endtask
    task automatic wr(input logic [7:0] a, input logic b);
        logic [7:0] d;
        d = 8'($random(seed));
        d[WSPC_GIE_BIT] = b;
        opt_wr_i <= 1'h1;
        opt_addr_i <= a;
        opt_data_i <= d;
        tick();
        opt_wr_i <= 1'h0;
        // enable copy on the port lags one cycle
        tick();
    endtask
    task automatic enter(input logic s, input int m);
        entry_i <= '{~s, s, wspc_core_mode_t'(m)};
        tick();
        entry_i <= '0;
    endtask
    // bounded: a lost wake must not hang the run
    task automatic wake_wait(output int k);
        k = 0;
        while (wake_o.wake !== 1'h1)
        begin
            if (k == 40)
            begin
                failures++;
                report_and_stop();
            end
            tick();
            k++;
        end
    endtask
    function automatic wspc_wake_t exp_wake(input int m, input logic nmi);
        return '{1'h1, (m == 0) ? WSPC_RESUME_SERVICE : WSPC_RESUME_NEXT,
            (m == 1) & nmi, m != 0};
    endfunction
    initial
    begin
        do_reset();
        wr(WSPC_IOPT_ADDR, 1'h1);
        check(global_interrupt_enable_o, 8'h01);
        set <= 2'h1;
        tick();
        set <= 2'h0;
        enter(1'h0, 0);
        check({entry_refused_o, core_halt_o}, 8'h02);
        wr(8'hc9, 1'h0);
        check(global_interrupt_enable_o, 8'h01);
        wr(WSPC_IOPT_ADDR, 1'h0);
        enter(1'h0, 0);
        set <= 2'h2;
        tick();
        set <= 2'h0;
        tick(10);
        check({core_halt_o, wake_o.wake}, 8'h02);
        do_reset();
        $display("test refuse, enable and reset done");
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 2; s++)
                for (int k = 0; k < 2; k++)
                begin
                    osc_sel_i <= 2'($random(seed));
                    {wdg_hw_i, wdg_sw_i} <= k ? 2'($random(seed)) : 2'h0;
                    nw = 1'($random(seed) & k);
                    wr(WSPC_IOPT_ADDR, 1'h1);
                    se = s[0] & ~(wdg_hw_i | wdg_sw_i);
                    enter(s[0], m);
                    check({core_halt_o, osc_run_o, periph_clk_en_o},
                        {5'h0, 1'h1, ~se, ~se});
                    set <= nw ? 2'h2 : 2'h1;
                    tick();
                    set <= 2'h0;
                    wake_wait(n);
                    check(se ? n >= S : n <= 2, 8'h01);
                    check(wake_o, exp_wake(m, nw));
                    check({core_halt_o, osc_sel_o}, {6'h0, osc_sel_i});
                    tick(2);
                end
        $display("test wake modes done");
        report_and_stop();
    end
endmodule
